// *** hdl/ssl_latch_bank.sv ***
// ssl_latch_bank: 3-wire serial port and the three write-only configuration latches,
// with the derived divider, lock detect and output gating state.
// assumes serial pins and the reference/phase pins are asynchronous and slow
// against CLK; everything is frozen while CLK_EN is low.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - control latch holds low and high three-bit charge pump current groups
// - mute-till-lock set keeps RF outputs off until lock is reported
// - gain bit 1 selects high current group, 0 selects low group
// - three-state bit 1 forces charge pump output to high impedance
// - polarity bit 1 positive, 0 negative for inverting loop filters
// - counter reset bit holds reference and A/B counters in reset
// - feedback latch holds 5-bit swallow count 0 to 31
// - feedback latch holds 13-bit main count, valid 3 to 8191
// - total feedback division is prescaler times main count plus swallow count
// - feedback and control gain bits share one bit, latest write wins
// - feedback bit 22 enables the output divide-by-2
// - feedback bit 23 routes the halved signal to the prescaler
// - control code 0,1 loads the reference latch on load rise
// - reference latch holds 14-bit divide ratio 1 to 16383
// - reference bits 16 and 17 select antibacklash pulse width
// - lock after five good reference cycles if precision bit set, else three
// - test bit should be zero; factory latch contents are ignored
// - band select clock is reference divider output through optional divider
// - shift on serial clock rise; load rise transfers last 24 bits
// - control code 0,0 loads the control latch on load rise
module ssl_latch_bank (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CLK_EN,
	input wire logic SER_CLK,
	input wire logic SER_DATA,
	input wire logic LOAD_ENABLE,
	input wire logic REF_IN,
	input wire logic PHASE_OK,
	output ssl_pkg::ssl_ctrl_t CTRL_LATCH,
	output ssl_pkg::ssl_fb_t FB_LATCH,
	output ssl_pkg::ssl_ref_t REF_LATCH,
	output logic CP_GAIN,
	output logic [2:0] CP_CURRENT,
	output logic CP_TRISTATE,
	output logic PHASE_POSITIVE,
	output logic COUNTER_RESET,
	output logic HALFRATE_OUTPUT_EN,
	output logic HALFRATE_PRESCALER_SRC,
	output logic [1:0] ANTIBACKLASH,
	output logic [17:0] FB_DIV_TOTAL,
	output logic REF_DIV_TICK,
	output logic BAND_CLK_TICK,
	output logic LOCKED,
	output logic RF_OUT_EN
);
	import ssl_pkg::*;

	// ==========================================================
	// pin synchronisers
	logic [PIN_N-1:0] sync1_reg;
	logic [PIN_N-1:0] sync2_reg;
	logic [PIN_N-1:0] sync3_reg;
	wire sclk_rise = sync2_reg[PIN_SCLK] & ~sync3_reg[PIN_SCLK];
	wire load_rise = sync2_reg[PIN_LOAD] & ~sync3_reg[PIN_LOAD];
	wire ref_rise = sync2_reg[PIN_REF] & ~sync3_reg[PIN_REF];
	wire phase_ok = sync2_reg[PIN_PHOK];

	// two flops per pin, third only for edge detection
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else if (CLK_EN) begin
			sync1_reg <= {PHASE_OK, REF_IN, LOAD_ENABLE, SER_DATA, SER_CLK};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// ==========================================================
	// input shift register and latch decode
	logic [SR_W-1:0] shift_reg;
	wire [SR_W-1:0] shift_next = {shift_reg[SR_W-2:0], sync2_reg[PIN_SDATA]};
	wire [1:0] latch_sel = shift_reg[1:0];
	wire [BODY_W-1:0] body = shift_reg[SR_W-1:2];
	wire ld_ctrl = load_rise && (latch_sel == SEL_CTRL);
	wire ld_fb = load_rise && (latch_sel == SEL_FB);
	wire ld_ref = load_rise && (latch_sel == SEL_REF);
	// factory latch code selects nothing here
	ssl_ctrl_t body_ctrl;
	ssl_fb_t body_fb;
	assign body_ctrl = ssl_ctrl_t'(body);
	assign body_fb = ssl_fb_t'(body);

	// shift msb first on each serial clock rise
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			shift_reg <= '0;
		end else if (CLK_EN && sclk_rise) begin
			shift_reg <= shift_next;
		end
	end

	// ==========================================================
	// configuration latches
	ssl_ctrl_t ctrl_reg;
	ssl_fb_t fb_reg;
	ssl_ref_t ref_reg;
	logic cp_gain_reg;
	wire cp_gain_next = ld_fb ? body_fb.cp_gain_sel : body_ctrl.cp_gain_sel;

	// load rise transfers the 22 field bits into the addressed latch
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_reg <= ssl_ctrl_t'(CTRL_RST);
			fb_reg <= ssl_fb_t'(FB_RST);
			ref_reg <= ssl_ref_t'(REF_RST);
			cp_gain_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (ld_ctrl)
				ctrl_reg <= body_ctrl;
			if (ld_fb)
				fb_reg <= body_fb;
			if (ld_ref)
				ref_reg <= ssl_ref_t'(body);
			if (ld_ctrl || ld_fb)
				cp_gain_reg <= cp_gain_next;
		end
	end

	// ==========================================================
	// reference divider, held while counter reset is set
	logic [13:0] ref_cnt_reg;
	logic ref_tick_reg;
	wire [13:0] ref_div_eff = (ref_reg.ref_div < REF_DIV_MIN) ? REF_DIV_MIN : ref_reg.ref_div;
	wire ref_wrap = (ref_cnt_reg >= ref_div_eff - REF_DIV_MIN);
	wire [13:0] ref_cnt_next = ref_wrap ? 14'h0000 : ref_cnt_reg + 14'h0001;
	wire ref_tick_next = ref_rise && ref_wrap && !ctrl_reg.counter_reset;

	// count reference edges, one tick per divide ratio
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ref_cnt_reg <= '0;
			ref_tick_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (ctrl_reg.counter_reset)
				ref_cnt_reg <= '0;
			else if (ref_rise)
				ref_cnt_reg <= ref_cnt_next;
			ref_tick_reg <= ref_tick_next;
		end
	end

	// ==========================================================
	// band select clock divider: 1, 2, 4 or 8
	logic [2:0] band_cnt_reg;
	logic band_tick_reg;
	wire [2:0] band_last = 3'((4'h1 << ref_reg.band_clk_div) - 4'h1);
	wire band_wrap = (band_cnt_reg >= band_last);
	wire band_tick_next = ref_tick_reg && band_wrap;

	// divide reference ticks down for the band select logic
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			band_cnt_reg <= '0;
			band_tick_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (ctrl_reg.counter_reset)
				band_cnt_reg <= '0;
			else if (ref_tick_reg)
				band_cnt_reg <= band_wrap ? 3'h0 : band_cnt_reg + 3'h1;
			band_tick_reg <= band_tick_next;
		end
	end

	// ==========================================================
	// digital lock detect on reference cycles
	logic [2:0] good_cnt_reg;
	logic locked_reg;
	wire [2:0] lock_need = ref_reg.lock_precision_sel ? LOCK_CYC_FINE : LOCK_CYC_COARSE;
	wire [2:0] good_sat = (good_cnt_reg >= LOCK_CYC_FINE) ? good_cnt_reg : good_cnt_reg + 3'h1;
	wire [2:0] good_next = phase_ok ? good_sat : 3'h0;

	// count consecutive good cycles, a bad cycle restarts
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			good_cnt_reg <= '0;
			locked_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (ctrl_reg.counter_reset)
				good_cnt_reg <= '0;
			else if (ref_tick_reg)
				good_cnt_reg <= good_next;
			locked_reg <= (good_cnt_reg >= lock_need);
		end
	end

	// ==========================================================
	// derived outputs, all registered
	wire [4:0] presc = ctrl_reg.prescaler_sel[0] ? PRESC_HI : PRESC_LO;
	wire [17:0] fb_total_next = 18'(presc * fb_reg.main_count) + 18'(fb_reg.swallow_count);
	wire [2:0] cp_cur_next = cp_gain_reg ? ctrl_reg.cp_current_high : ctrl_reg.cp_current_low;
	wire rf_en_next = !ctrl_reg.mute_till_lock || locked_reg;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			FB_DIV_TOTAL <= '0;
			CP_CURRENT <= '0;
			RF_OUT_EN <= 1'b1;
		end else if (CLK_EN) begin
			FB_DIV_TOTAL <= fb_total_next;
			CP_CURRENT <= cp_cur_next;
			RF_OUT_EN <= rf_en_next;
		end
	end

	// field outputs straight from latch flops, ticks and lock from their own flops
	assign CTRL_LATCH = ctrl_reg;
	assign FB_LATCH = fb_reg;
	assign REF_LATCH = ref_reg;
	assign CP_GAIN = cp_gain_reg;
	assign CP_TRISTATE = ctrl_reg.cp_tristate;
	assign PHASE_POSITIVE = ctrl_reg.phase_polarity_sel;
	assign COUNTER_RESET = ctrl_reg.counter_reset;
	assign HALFRATE_OUTPUT_EN = fb_reg.halfrate_output_en;
	assign HALFRATE_PRESCALER_SRC = fb_reg.halfrate_prescaler_src;
	assign ANTIBACKLASH = ref_reg.antibacklash;
	assign REF_DIV_TICK = ref_tick_reg;
	assign BAND_CLK_TICK = band_tick_reg;
	assign LOCKED = locked_reg;
endmodule : ssl_latch_bank

`default_nettype wire

// *** hdl/ssl_pkg.sv ***
// ssl_pkg: constants, field layouts and reset values of the serial latch bank.
// assumes a 125 MHz system clock; the serial port pins are asynchronous to it.
package ssl_pkg;
	// ==========================================================
	// serial word framing
	localparam int SR_W = 24;
	localparam int BODY_W = 22;
	localparam logic [1:0] SEL_CTRL = 2'h0; // latch_sel_bit1,bit0 = 0,0
	localparam logic [1:0] SEL_REF = 2'h1; // 0,1
	localparam logic [1:0] SEL_FB = 2'h2; // 1,0
	localparam logic [1:0] SEL_TEST = 2'h3; // 1,1, factory latch
	// ==========================================================
	// pin synchroniser bit positions
	localparam int PIN_N = 5;
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_LOAD = 2;
	localparam int PIN_REF = 3;
	localparam int PIN_PHOK = 4;
	// ==========================================================
	// timing: host serial clock bound, in ns and in system cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int SCLK_MAX_MHZ = 20;
	localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
	localparam int SCLK_MIN_PERIOD_CYC = SCLK_MIN_PERIOD_NS / CLK_PERIOD_NS;
	// ==========================================================
	// divider and lock constants
	localparam logic [4:0] PRESC_LO = 5'h08;
	localparam logic [4:0] PRESC_HI = 5'h10;
	localparam logic [2:0] LOCK_CYC_FINE = 3'h5;
	localparam logic [2:0] LOCK_CYC_COARSE = 3'h3;
	localparam logic [13:0] REF_DIV_MIN = 14'h0001;
	// ==========================================================
	// latch layouts, bit 21 of each struct is serial bit 23
	typedef struct packed {
		logic [1:0] prescaler_sel;
		logic [1:0] power_down;
		logic [2:0] cp_current_high; // cp_current_high_bit0 is lsb
		logic [2:0] cp_current_low; // cp_current_low_bit0 is lsb
		logic [1:0] out_power;
		logic mute_till_lock;
		logic cp_gain_sel;
		logic cp_tristate;
		logic phase_polarity_sel;
		logic [2:0] test_mux_output;
		logic counter_reset;
		logic [1:0] core_power; // core_power_bit1, core_power_bit0
	} ssl_ctrl_t;
	typedef struct packed {
		logic halfrate_prescaler_src;
		logic halfrate_output_en;
		logic cp_gain_sel;
		logic [12:0] main_count;
		logic spare;
		logic [4:0] swallow_count;
	} ssl_fb_t;
	typedef struct packed {
		logic [1:0] spare;
		logic [1:0] band_clk_div;
		logic factory_test_sel;
		logic lock_precision_sel;
		logic [1:0] antibacklash;
		logic [13:0] ref_div;
	} ssl_ref_t;
	localparam logic [21:0] CTRL_RST = 22'h000000;
	localparam logic [21:0] FB_RST = 22'h000000;
	localparam logic [21:0] REF_RST = 22'h000000;
endpackage : ssl_pkg

// *** tb/ssl_host.sv ***
// ssl_host: host side of the 3-wire port plus reference and phase pins.
// assumes tasks are called from the bench at falling CLK edges.
`timescale 1ns/100ps
`default_nettype none
module ssl_host (
	input wire logic CLK,
	output var logic SER_CLK,
	output var logic SER_DATA,
	output var logic LOAD_ENABLE,
	output var logic REF_IN,
	output var logic PHASE_OK
);
	// ==========================================================
	// serial word, msb first, junk bits ahead of it
	task automatic send(input logic [23:0] w, input int junk);
		for (int i = -junk; i < 24; i++) begin
			@(negedge CLK) SER_CLK = 1'b0;
			SER_DATA = (i < 0) ? 1'b1 : w[23 - i];
			repeat (4) @(negedge CLK);
			SER_CLK = 1'b1; // 72 ns period
			repeat (4) @(negedge CLK);
		end
		SER_CLK = 1'b0;
		SER_DATA = ~SER_DATA; // last bit inverted, no stale level
		repeat (4) @(negedge CLK);
		LOAD_ENABLE = 1'b1;
		repeat (8) @(negedge CLK);
		LOAD_ENABLE = 1'b0;
	endtask : send
	// one reference edge with its phase verdict
	task automatic ref_pulse(input logic ok);
		@(negedge CLK) REF_IN = 1'b1;
		PHASE_OK = ok;
		repeat (4) @(negedge CLK);
		REF_IN = 1'b0;
		repeat (3) @(negedge CLK);
	endtask : ref_pulse
	initial {SER_CLK, SER_DATA, LOAD_ENABLE, REF_IN, PHASE_OK} = 5'h00;
endmodule : ssl_host
`default_nettype wire

// *** tb/ssl_latch_bank_monitor.sv ***
// ssl_monitor: port assertions of the serial latch bank.
// assumes CLK_EN is held high; bound into ssl_latch_bank below.
`timescale 1ns/100ps
`default_nettype none
module ssl_monitor (
	input wire logic CLK,
	input wire logic RSTN,
	input wire ssl_pkg::ssl_ctrl_t CTRL_LATCH,
	input wire ssl_pkg::ssl_fb_t FB_LATCH,
	input wire ssl_pkg::ssl_ref_t REF_LATCH,
	input wire logic CP_GAIN,
	input wire logic [2:0] CP_CURRENT,
	input wire logic CP_TRISTATE,
	input wire logic PHASE_POSITIVE,
	input wire logic COUNTER_RESET,
	input wire logic HALFRATE_OUTPUT_EN,
	input wire logic HALFRATE_PRESCALER_SRC,
	input wire logic [1:0] ANTIBACKLASH,
	input wire logic [17:0] FB_DIV_TOTAL,
	input wire logic REF_DIV_TICK,
	input wire logic LOCKED,
	input wire logic RF_OUT_EN
);
	import ssl_pkg::*;
	// ==========================================================
	// field maps and derived outputs
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	a_current_group: assert property (CP_CURRENT == ($past(CP_GAIN) ?
		$past(CTRL_LATCH.cp_current_high) : $past(CTRL_LATCH.cp_current_low))) else $error("current group");
	a_tristate_map: assert property ($stable(CTRL_LATCH) |-> CP_TRISTATE == CTRL_LATCH.cp_tristate)
		else $error("three-state map");
	a_polarity_map: assert property ($stable(CTRL_LATCH) |-> PHASE_POSITIVE == CTRL_LATCH.phase_polarity_sel)
		else $error("polarity map");
	a_reset_no_tick: assert property (COUNTER_RESET && $past(COUNTER_RESET, 2) |-> !REF_DIV_TICK)
		else $error("tick in counter reset");
	a_fb_total: assert property ($stable(CTRL_LATCH) && $stable(FB_LATCH) |-> FB_DIV_TOTAL ==
		(CTRL_LATCH.prescaler_sel[0] ? 18'h10 : 18'h08) * FB_LATCH.main_count + FB_LATCH.swallow_count)
		else $error("feedback total");
	a_halfrate_map: assert property ($stable(FB_LATCH) |-> {HALFRATE_PRESCALER_SRC, HALFRATE_OUTPUT_EN} ==
		{FB_LATCH.halfrate_prescaler_src, FB_LATCH.halfrate_output_en}) else $error("halfrate map");
	a_backlash_map: assert property ($stable(REF_LATCH) |-> ANTIBACKLASH == REF_LATCH.antibacklash)
		else $error("antibacklash map");
	a_rf_mute: assert property (RF_OUT_EN == !($past(CTRL_LATCH.mute_till_lock) && !$past(LOCKED)))
		else $error("rf mute");
endmodule : ssl_monitor
bind ssl_latch_bank ssl_monitor ssl_monitor_inst (.CLK, .RSTN, .CTRL_LATCH, .FB_LATCH, .REF_LATCH, .CP_GAIN,
	.CP_CURRENT, .CP_TRISTATE, .PHASE_POSITIVE, .COUNTER_RESET, .HALFRATE_OUTPUT_EN, .HALFRATE_PRESCALER_SRC,
	.ANTIBACKLASH, .FB_DIV_TOTAL, .REF_DIV_TICK, .LOCKED, .RF_OUT_EN);
`default_nettype wire

// *** tb/tb_ssl_latch_bank.sv ***
// tb_ssl_latch_bank: directed writes, lock and counter reset checks.
// assumes ssl_pkg and the monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_ssl_latch_bank;
	import ssl_pkg::*;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	int n_errors = 0;
	int samples_checked = 0;
	int ticks = 0;
	int bticks = 0;
	int np;
	int t0;
	logic [21:0] wc, wf, wr;
	wire logic sclk, sdat, ld, rin, pok;
	ssl_ctrl_t ctrl;
	ssl_fb_t fb;
	ssl_ref_t rf;
	logic gain, tri_s, pol, crst, hoe, hps, rtick, btick, lck, rfen;
	logic [2:0] cur;
	logic [1:0] abl;
	logic [17:0] tot;
	ssl_host ssl_host_inst (.CLK(CLK), .SER_CLK(sclk), .SER_DATA(sdat), .LOAD_ENABLE(ld), .REF_IN(rin),
		.PHASE_OK(pok));
	ssl_latch_bank ssl_latch_bank_inst (.CLK(CLK), .RSTN(RSTN), .CLK_EN(1'b1), .SER_CLK(sclk), .SER_DATA(sdat),
		.LOAD_ENABLE(ld), .REF_IN(rin), .PHASE_OK(pok), .CTRL_LATCH(ctrl), .FB_LATCH(fb), .REF_LATCH(rf),
		.CP_GAIN(gain), .CP_CURRENT(cur), .CP_TRISTATE(tri_s), .PHASE_POSITIVE(pol), .COUNTER_RESET(crst),
		.HALFRATE_OUTPUT_EN(hoe), .HALFRATE_PRESCALER_SRC(hps), .ANTIBACKLASH(abl), .FB_DIV_TOTAL(tot),
		.REF_DIV_TICK(rtick), .BAND_CLK_TICK(btick), .LOCKED(lck), .RF_OUT_EN(rfen));
	always #4 CLK = ~CLK;
	always @(posedge CLK) if (rtick === 1'b1) ticks <= ticks + 1;
	// band select ticks, divide-by-4 code expected
	always @(posedge CLK) if (btick === 1'b1) bticks <= bticks + 1;
	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic run_to(input int t, input logic ok, output int n);
		for (n = 0; n < 40 && ticks < t; n++) ssl_host_inst.ref_pulse(ok);
		repeat (4) @(negedge CLK);
	endtask : run_to
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude
	// ==========================================================
	// tests
	initial begin
		repeat (3) @(negedge CLK);
		RSTN = 1'b1;
		repeat (4) @(negedge CLK);
		chk("reset", 22'h000000, ctrl | fb | rf);
		chk("rf_en", 22'h1, 22'(rfen));
		$display("test reset done");
		wr = {2'h0, 2'h2, 1'h0, 1'h1, 2'h3, 14'h0003};
		ssl_host_inst.send({wr, SEL_REF}, 5);
		chk("ref", wr, rf);
		wc = {2'h1, 2'h0, 3'h5, 3'h2, 2'h0, 4'hF, 3'h0, 1'h0, 2'h1};
		ssl_host_inst.send({wc, SEL_CTRL}, 0);
		chk("ctrl", wc, ctrl);
		chk("gain", {1'h1, 3'h5, 2'h3, 1'h0}, {gain, cur, tri_s, pol, rfen});
		wf = {1'h1, 1'h1, 1'h0, 13'h0003, 1'h0, 5'h1F};
		ssl_host_inst.send({wf, SEL_FB}, 0);
		chk("fb", wf, fb);
		chk("gain_fb", {1'h0, 3'h2, 2'h3}, {gain, cur, hoe, hps});
		chk("total", 22'h00004F, 22'(tot));
		ssl_host_inst.send({22'h3FFFFF, SEL_TEST}, 0);
		chk("test_code_ctrl", wc, ctrl);
		chk("test_code_fb", wf, fb);
		chk("test_code_ref", wr, rf);
		$display("test writes done");
		run_to(4, 1'b1, np);
		chk("lock_4", 22'h0, 22'(lck));
		run_to(5, 1'b1, np);
		chk("ref_ratio", 22'h3, 22'(np));
		chk("lock_5", 22'h3, {lck, rfen});
		run_to(6, 1'b0, np);
		chk("unlock", 22'h0, {lck, rfen});
		ssl_host_inst.send({wr & 22'h3EFFFF, SEL_REF}, 0);
		run_to(ticks + 2, 1'b1, np);
		chk("lock_2", 22'h0, 22'(lck));
		run_to(ticks + 1, 1'b1, np);
		chk("lock_3", 22'h1, 22'(lck));
		chk("band_ticks", 22'h2, 22'(bticks));
		$display("test lock done");
		ssl_host_inst.send({wc | 22'h000004, SEL_CTRL}, 0);
		t0 = ticks;
		run_to(t0 + 1, 1'b1, np);
		chk("crst_ticks", 22'h1, {21'(ticks - t0), crst});
		$display("test counter reset done");
		conclude();
	end
	initial begin
		#100000;
		n_errors++;
		$display("watchdog expired");
		conclude();
	end
endmodule : tb_ssl_latch_bank
`default_nettype wire
